// file: inc/pfg_pkg.sv
/*
   Constants shared by the mixed-signal port block: register offsets,
   reset values, field positions and comparator mode codes.
   Assumes a byte-wide register port with an 8-bit address.
*/
`default_nettype none

package pfg_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PFG_OFS_PIN_LEVEL  = 8'h00;
   localparam logic [7:0] PFG_OFS_LATCH      = 8'h01;
   localparam logic [7:0] PFG_OFS_DIRECTION  = 8'h02;
   localparam logic [7:0] PFG_OFS_ADC_CFG    = 8'h03;
   localparam logic [7:0] PFG_OFS_CMP_CTRL   = 8'h04;
   localparam logic [7:0] PFG_OFS_VREF_CTRL  = 8'h05;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PFG_RST_LATCH      = 8'h00;
   localparam logic [7:0] PFG_RST_DIRECTION  = 8'hff;
   localparam logic [5:0] PFG_RST_ADC_CFG    = 6'h00;
   localparam logic [5:0] PFG_RST_CMP_CTRL   = 6'h07;
   localparam logic [7:0] PFG_RST_VREF_CTRL  = 8'h00;

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int PFG_ADC_CFG_W      = 6;
   localparam int PFG_CMP_CTRL_W     = 6;
   localparam int PFG_REF_GEN_EN_BIT = 7;
   localparam int PFG_REF_OUT_EN_BIT = 6;
   localparam int PFG_PIN_CMP_TWO    = 1;
   localparam int PFG_PIN_CMP_ONE    = 2;
   localparam int PFG_PIN_REF_OUT    = 5;
   localparam int PFG_PIN_SLAVE_SEL  = 7;

   // ----------------------------------------------------------------
   // converter channel mapping: pin i is channel i + base
   // ----------------------------------------------------------------
   localparam logic [4:0] PFG_CHAN_BASE      = 5'h05;
   localparam logic [4:0] PFG_CHAN_LIMIT     = 5'h0f;

   // ----------------------------------------------------------------
   // comparator modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PFG_CMP_RESET     = 3'b000,
      PFG_CMP_OUT_BOTH  = 3'b011,
      PFG_CMP_OUT_ONE   = 3'b101,
      PFG_CMP_OFF       = 3'b111
   } pfg_cmp_mode_t;

   // comparator input pins, used while comparators are on
   localparam logic [7:0] PFG_CMP_IN_PINS    = 8'h78;

endpackage

`default_nettype wire

// file: hw/pfg_sync.sv
/*
   Two-stage synchroniser for a vector of asynchronous levels.
   Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/10ps
`default_nettype none

module pfg_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // ----------------------------------------------------------------
   // two flip-flops, the first read only by the second
   // ----------------------------------------------------------------

   // idle high in reset: no false low (slave select) after release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage_one <= '1;
         sync_out  <= '1;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

`default_nettype wire

// file: hw/pfg_port.sv
/*
   Eight-bit mixed-signal general-purpose port with register port.
   Assumes pins, comparator results and the reset arrive asynchronously;
   the register master runs on clk_sys.
*/
// Chosen here: the register addresses and the address-and-strobe port.
// Function
// R1: direction 0 drives the pin from the latch, analog select ignored.
// R2: direction 1 makes an input; analog select blocks digital input.
// R3: after reset pins 0..6 are analog, channels 5..11 in pin order.
// R4: comparator two output enabled and pin 1 output drives its result.
// R5: comparator one output enabled and pin 2 output drives its result.
// R6: reference output enabled disables digital in and out on pin 5.
// R7: pin 7 as input feeds the serial slave-select as well as reads.
// R8: pin 0 and bit 0 exist only in the largest package variant.
// R9: analog select on pins 4 and 6 leaves the output driver alone.
// R10: writing the port data register stores into the output latches.
// R11: software turns comparators off and converter digital before use.
// R12: unimplemented register bits read as zero.
// R13: after reset pins 0..6 are analog and read back as zero.
// R14: latch register reads return the latch, not the pin level.
// R15: direction 1 tristates the driver, direction 0 enables it.
// R16: analog select decoded from converter field and comparator mode.
`timescale 1ns/10ps
`default_nettype none

module pfg_port #(
   parameter bit PIN0_PRESENT = 1'b1
) (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe_n,
   input  wire logic       comparator_one_raw,
   input  wire logic       comparator_two_raw,
   output logic      [7:0] analog_select,
   output logic            reference_voltage_out,
   output logic            serial_slave_select_in
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic       rst_n;
   logic [7:0] output_latch_f;
   logic [7:0] direction_f;
   logic [5:0] adc_port_config;
   logic [5:0] comparator_control;
   logic [7:0] voltage_ref_control;
   logic [7:0] pin_sync;
   logic [1:0] cmp_sync;
   logic       comparator_one_result;
   logic       comparator_two_result;
   logic [7:0] impl_mask;
   logic [7:0] next_analog;
   logic [7:0] next_pin_out;
   logic [7:0] next_oe_n;
   logic [7:0] pin_level_f;
   logic [7:0] next_rdata;
   logic       ref_output_enable;
   logic       ref_generator_enable;
   logic [2:0] comparator_mode;
   logic [3:0] analog_pin_select;
   logic [1:0] ref_voltage_select;
   logic       wr_latch;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // channel of pin i is analog when below the field's limit
   function automatic logic chan_analog(
      input logic [2:0] pin,
      input logic [3:0] cfg
   );
      logic [5:0] sum;
      sum = {3'b000, pin} + {1'b0, pfg_pkg::PFG_CHAN_BASE}
          + {2'b00, cfg};
      return (sum < {1'b0, pfg_pkg::PFG_CHAN_LIMIT});
   endfunction

   // register write hit on one offset
   function automatic logic wr_hit(
      input logic       wr,
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      return wr && (addr == ofs);
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------

   // asynchronous assert, two-flop release
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------

   // pin levels
   pfg_sync #(
      .WIDTH (8)
   ) u_pin_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // comparator results from the analog side
   pfg_sync #(
      .WIDTH (2)
   ) u_cmp_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in ({comparator_two_raw, comparator_one_raw}),
      .sync_out (cmp_sync)
   );

   assign comparator_one_result = cmp_sync[0];
   assign comparator_two_result = cmp_sync[1];

   // ----------------------------------------------------------------
   // field aliases
   // ----------------------------------------------------------------

   // R8: bit 0 present
   assign impl_mask = {7'h7f, PIN0_PRESENT};

   assign analog_pin_select    = adc_port_config[3:0];
   assign ref_voltage_select   = adc_port_config[5:4];
   assign comparator_mode      = comparator_control[2:0];
   assign ref_generator_enable =
      voltage_ref_control[pfg_pkg::PFG_REF_GEN_EN_BIT];
   assign ref_output_enable    =
      voltage_ref_control[pfg_pkg::PFG_REF_OUT_EN_BIT];

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------

   // R10: both data offsets load the latch
   assign wr_latch =
      wr_hit(reg_wr, reg_addr, pfg_pkg::PFG_OFS_PIN_LEVEL) ||
      wr_hit(reg_wr, reg_addr, pfg_pkg::PFG_OFS_LATCH);

   // output latches
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         output_latch_f <= pfg_pkg::PFG_RST_LATCH;
      end else if (wr_latch) begin
         // R8: absent bit 0 holds zero
         output_latch_f <= reg_wdata & impl_mask;
      end
   end

   // direction bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         direction_f <= pfg_pkg::PFG_RST_DIRECTION;
      end else if (wr_hit(reg_wr, reg_addr,
                          pfg_pkg::PFG_OFS_DIRECTION)) begin
         direction_f <= reg_wdata | ~impl_mask;
      end
   end

   // converter port configuration
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // R3: field zero makes channels 5..11 analog
         adc_port_config <= pfg_pkg::PFG_RST_ADC_CFG;
      end else if (wr_hit(reg_wr, reg_addr,
                          pfg_pkg::PFG_OFS_ADC_CFG)) begin
         // R12: top two bits not stored
         adc_port_config <= reg_wdata[5:0];
      end
   end

   // comparator control, writable bits only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         comparator_control <= pfg_pkg::PFG_RST_CMP_CTRL;
      end else if (wr_hit(reg_wr, reg_addr,
                          pfg_pkg::PFG_OFS_CMP_CTRL)) begin
         comparator_control <= reg_wdata[5:0];
      end
   end

   // reference voltage control
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         voltage_ref_control <= pfg_pkg::PFG_RST_VREF_CTRL;
      end else if (wr_hit(reg_wr, reg_addr,
                          pfg_pkg::PFG_OFS_VREF_CTRL)) begin
         voltage_ref_control <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // analog selection
   // ----------------------------------------------------------------

   // R16: converter field plus comparator inputs while on
   always_comb begin
      next_analog = 8'h00;
      for (int i = 0; i < 7; i++) begin
         next_analog[i] = chan_analog(3'(i), analog_pin_select);
      end
      if (pfg_pkg::pfg_cmp_mode_t'(comparator_mode)
          != pfg_pkg::PFG_CMP_OFF) begin
         next_analog = next_analog | pfg_pkg::PFG_CMP_IN_PINS;
      end
      next_analog = next_analog & impl_mask;
   end

   // registered select to the converter
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         analog_select <= 8'h7f & {7'h7f, PIN0_PRESENT};
      end else begin
         analog_select <= next_analog;
      end
   end

   // ----------------------------------------------------------------
   // output drivers
   // ----------------------------------------------------------------

   // R1: latch drives output pins; R9: analog not consulted
   always_comb begin
      next_pin_out = output_latch_f;
      // R4: comparator two result on pin 1
      if (pfg_pkg::pfg_cmp_mode_t'(comparator_mode)
          == pfg_pkg::PFG_CMP_OUT_BOTH) begin
         next_pin_out[pfg_pkg::PFG_PIN_CMP_TWO] = comparator_two_result;
      end
      // R5: comparator one result on pin 2
      if (pfg_pkg::pfg_cmp_mode_t'(comparator_mode)
          == pfg_pkg::PFG_CMP_OUT_BOTH ||
          pfg_pkg::pfg_cmp_mode_t'(comparator_mode)
          == pfg_pkg::PFG_CMP_OUT_ONE) begin
         next_pin_out[pfg_pkg::PFG_PIN_CMP_ONE] = comparator_one_result;
      end
   end

   // R15: enable low where direction is zero
   always_comb begin
      next_oe_n = direction_f | ~impl_mask;
      // R6: reference output takes pin 5 away
      if (ref_output_enable) begin
         next_oe_n[pfg_pkg::PFG_PIN_REF_OUT] = 1'b1;
      end
   end

   // driver flip-flops, all tristated at reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_out  <= 8'h00;
         pin_oe_n <= 8'hff;
      end else begin
         pin_out  <= next_pin_out & impl_mask;
         pin_oe_n <= next_oe_n;
      end
   end

   // reference output state to the analog side
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reference_voltage_out <= 1'b0;
      end else begin
         reference_voltage_out <= ref_output_enable;
      end
   end

   // ----------------------------------------------------------------
   // input path
   // ----------------------------------------------------------------

   // R2: analog selection blocks the digital input
   // R13: analog pins read as zero
   always_comb begin
      pin_level_f = pin_sync & ~next_analog & impl_mask;
      // R6: reference output disables pin 5 input
      if (ref_output_enable) begin
         pin_level_f[pfg_pkg::PFG_PIN_REF_OUT] = 1'b0;
      end
   end

   // R7: pin 7 as input feeds the serial port
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         serial_slave_select_in <= 1'b1;
      end else if (direction_f[pfg_pkg::PFG_PIN_SLAVE_SEL]) begin
         serial_slave_select_in <= pin_sync[pfg_pkg::PFG_PIN_SLAVE_SEL];
      end else begin
         serial_slave_select_in <= 1'b1; // deselected when output
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------

   // read mux; unmapped offsets return zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         pfg_pkg::PFG_OFS_PIN_LEVEL: begin
            next_rdata = pin_level_f;
         end
         pfg_pkg::PFG_OFS_LATCH: begin
            // R14: latch value, not pin
            next_rdata = output_latch_f;
         end
         pfg_pkg::PFG_OFS_DIRECTION: begin
            // R8: absent bit 0 reads zero
            next_rdata = direction_f & impl_mask;
         end
         pfg_pkg::PFG_OFS_ADC_CFG: begin
            // R12: top bits zero
            next_rdata = {2'b00, ref_voltage_select, analog_pin_select};
         end
         pfg_pkg::PFG_OFS_CMP_CTRL: begin
            next_rdata = {comparator_two_result, comparator_one_result,
                          comparator_control};
         end
         pfg_pkg::PFG_OFS_VREF_CTRL: begin
            next_rdata = {ref_generator_enable, ref_output_enable,
                          voltage_ref_control[5:0]};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// file: bench/pfg_port_props.sv
/*
   Checker for the mixed-signal port: shadow registers and port timing.
   Assumes it is bound to pfg_port and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none

module pfg_port_props #(
   parameter bit PIN0_PRESENT = 1'b1
) (
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic       comparator_one_raw,
   input wire logic       comparator_two_raw,
   input wire logic [7:0] analog_select,
   input wire logic       reference_voltage_out,
   input wire logic       serial_slave_select_in
);
   // ----------------------------------------------------------------
   // shadow registers
   // ----------------------------------------------------------------
   logic [7:0] lat;
   logic [7:0] dir;
   logic [5:0] adc;
   logic [5:0] cmp;
   logic [7:0] vr;
   logic       ov1;
   logic       ov2;

   // comparator results take over pins 2 and 1
   assign ov2 = cmp[2:0] == pfg_pkg::PFG_CMP_OUT_BOTH;
   assign ov1 = ov2 | (cmp[2:0] == pfg_pkg::PFG_CMP_OUT_ONE);

   // follow software writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lat <= pfg_pkg::PFG_RST_LATCH;
         dir <= pfg_pkg::PFG_RST_DIRECTION;
         adc <= pfg_pkg::PFG_RST_ADC_CFG;
         cmp <= pfg_pkg::PFG_RST_CMP_CTRL;
         vr  <= pfg_pkg::PFG_RST_VREF_CTRL;
      end else if (reg_wr) begin
         case (reg_addr)
            pfg_pkg::PFG_OFS_PIN_LEVEL,
            pfg_pkg::PFG_OFS_LATCH:
               lat <= reg_wdata & {7'h7f, PIN0_PRESENT};
            pfg_pkg::PFG_OFS_DIRECTION:
               dir <= reg_wdata | {7'h00, !PIN0_PRESENT};
            pfg_pkg::PFG_OFS_ADC_CFG:   adc <= reg_wdata[5:0];
            pfg_pkg::PFG_OFS_CMP_CTRL:  cmp <= reg_wdata[5:0];
            pfg_pkg::PFG_OFS_VREF_CTRL: vr  <= reg_wdata;
            default: ;
         endcase
      end
   end

   // analog pins from converter field and comparator mode
   function automatic logic [7:0] dec(input logic [3:0] c,
                                      input logic [2:0] m);
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 7; i++) begin
         d[i] = (i + 5 + int'(c)) < 15;
      end
      if (m != pfg_pkg::PFG_CMP_OFF) begin
         d = d | pfg_pkg::PFG_CMP_IN_PINS;
      end
      d[0] = d[0] & PIN0_PRESENT;
      return d;
   endfunction

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   AST_OE_DIR:
   assert property (pin_oe_n == ($past(dir) | {2'h0, $past(vr[6]), 5'h00}))
      else $error("pin enable does not follow direction");
   AST_OUT_LAT:
   assert property (((pin_out ^ $past(lat)) & {2'h3, !$past(vr[6]), 2'h3,
      !$past(ov1), !$past(ov2), 1'h1}) == 8'h00)
      else $error("pin drive does not follow latch");
   AST_CMP_TWO:
   assert property ((ov2 && $stable(comparator_two_raw))[*6]
      |-> pin_out[1] == comparator_two_raw)
      else $error("pin 1 does not carry comparator two");
   AST_CMP_ONE:
   assert property ((ov1 && $stable(comparator_one_raw))[*6]
      |-> pin_out[2] == comparator_one_raw)
      else $error("pin 2 does not carry comparator one");
   AST_ANA_SEL:
   assert property (analog_select == dec($past(adc[3:0]), $past(cmp[2:0])))
      else $error("analog select decode wrong");
   AST_REF_OUT:
   assert property (reference_voltage_out == $past(vr[6]))
      else $error("reference output enable wrong");
   AST_SS_IN:
   assert property ((dir[7] && $stable(pin_in[7]))[*6]
      |-> serial_slave_select_in == pin_in[7])
      else $error("slave select does not follow pin 7");
   AST_SS_OUT:
   assert property (!$past(dir[7]) |-> serial_slave_select_in)
      else $error("slave select not idle with pin 7 output");
   AST_RD_LAT:
   assert property ($past(reg_rd) && $past(reg_addr) == pfg_pkg::PFG_OFS_LATCH
      |-> reg_rdata == $past(lat))
      else $error("latch read wrong");
   AST_RD_CFG:
   assert property ($past(reg_rd) && $past(reg_addr) == pfg_pkg::PFG_OFS_ADC_CFG
      |-> reg_rdata == {2'h0, $past(adc)})
      else $error("converter config read wrong");
   AST_RD_GAP:
   assert property ($past(reg_rd)
      && $past(reg_addr) > pfg_pkg::PFG_OFS_VREF_CTRL |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   COV_CMP_BOTH: cover property (ov2 && !pin_oe_n[1]);
   COV_REF_OUT:  cover property (reference_voltage_out);
   COV_WR_RD:    cover property ($past(reg_wr) && reg_rd);
endmodule

bind pfg_port pfg_port_props #(.PIN0_PRESENT(PIN0_PRESENT)) u_props (
   .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .pin_in, .pin_out, .pin_oe_n, .comparator_one_raw, .comparator_two_raw,
   .analog_select, .reference_voltage_out, .serial_slave_select_in);

`default_nettype wire

// file: bench/port_f_mixed_signal_gpio_tb_top.sv
/*
   Self-checking bench for the mixed-signal port, one task per scenario.
   Assumes pfg_port with default parameters and the checker bound to it.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) begin \
         $display("[ERR] %s exp %h got %h", nm, ex, got); \
         n_fail++; \
      end \
   end

module port_f_mixed_signal_gpio_tb_top;
   localparam int TMO = 5000;
   logic       clk_sys;
   logic       arst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe_n;
   logic       cmp1;
   logic       cmp2;
   logic [7:0] analog_select;
   logic       ref_out;
   logic       ss_in;
   int         n_fail;
   int         n_compared;
   int         cyc = 0;

   pfg_port DUT (
      .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .comparator_one_raw(cmp1),
      .comparator_two_raw(cmp2), .analog_select(analog_select),
      .reference_voltage_out(ref_out), .serial_slave_select_in(ss_in));

   // ----------------------------------------------------------------
   // bus and check helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'h0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [7:0] ex);
      @(posedge clk_sys);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'h0;
      @(negedge clk_sys);
      `CHK(nm, ex, reg_rdata)
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] ex [7] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h07, 8'h00, 8'h00};
      `CHK("analog_select", 8'h7f, analog_select)
      `CHK("pin_oe_n", 8'hff, pin_oe_n)
      for (int a = 0; a < 7; a++) begin
         rd_chk("reset read", 8'(a), ex[a]);
      end
      $display("t_reset done");
   endtask

   task automatic t_digital();
      wr(pfg_pkg::PFG_OFS_CMP_CTRL, 8'h07);
      wr(pfg_pkg::PFG_OFS_ADC_CFG, 8'h0f);
      wr(pfg_pkg::PFG_OFS_LATCH, 8'ha5);
      wr(pfg_pkg::PFG_OFS_PIN_LEVEL, 8'h00);
      rd_chk("latch", pfg_pkg::PFG_OFS_LATCH, 8'h00);
      wr(pfg_pkg::PFG_OFS_LATCH, 8'ha5);
      wr(pfg_pkg::PFG_OFS_DIRECTION, 8'hce);
      settle(1);
      `CHK("pin_oe_n", 8'hce, pin_oe_n)
      `CHK("pin_out", 8'ha5, pin_out)
      `CHK("analog_select", 8'h00, analog_select)
      rd_chk("latch", pfg_pkg::PFG_OFS_LATCH, 8'ha5);
      rd_chk("pins", pfg_pkg::PFG_OFS_PIN_LEVEL, 8'hff);
      wr(pfg_pkg::PFG_OFS_PIN_LEVEL, 8'h3c);
      wr(pfg_pkg::PFG_OFS_ADC_CFG, 8'h00);
      wr(pfg_pkg::PFG_OFS_DIRECTION, 8'h00);
      settle(6);
      `CHK("pin_out", 8'h3c, pin_out)
      `CHK("pin_oe_n", 8'h00, pin_oe_n)
      rd_chk("pins", pfg_pkg::PFG_OFS_PIN_LEVEL, 8'h80);
      $display("t_digital done");
   endtask

   task automatic t_decode();
      int n;
      for (int c = 0; c < 16; c++) begin
         n = (c >= 10) ? 0 : ((10 - c > 7) ? 7 : 10 - c);
         wr(pfg_pkg::PFG_OFS_ADC_CFG, {4'hd, 4'(c)});
         rd_chk("adc cfg", pfg_pkg::PFG_OFS_ADC_CFG, {4'h1, 4'(c)});
         `CHK("analog_select", 8'((1 << n) - 1), analog_select)
      end
      $display("t_decode done");
   endtask

   task automatic t_comparators();
      logic [2:0] md [5] = '{pfg_pkg::PFG_CMP_OUT_BOTH,
         pfg_pkg::PFG_CMP_OUT_BOTH, pfg_pkg::PFG_CMP_OUT_ONE,
         pfg_pkg::PFG_CMP_OUT_ONE, pfg_pkg::PFG_CMP_OFF};
      logic       r1 [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
      logic       r2 [5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
      logic [7:0] eo [5] = '{8'h04, 8'h02, 8'h04, 8'h00, 8'h00};
      logic [7:0] ea [5] = '{8'h78, 8'h78, 8'h78, 8'h78, 8'h00};
      wr(pfg_pkg::PFG_OFS_LATCH, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(pfg_pkg::PFG_OFS_CMP_CTRL, {5'h00, md[k]});
         cmp1 <= r1[k];
         cmp2 <= r2[k];
         settle(6);
         `CHK("pin_out", eo[k], pin_out)
         `CHK("analog_select", ea[k], analog_select)
      end
      $display("t_comparators done");
   endtask

   task automatic t_vref();
      wr(pfg_pkg::PFG_OFS_LATCH, 8'hff);
      wr(pfg_pkg::PFG_OFS_VREF_CTRL, 8'h40);
      settle(1);
      `CHK("pin_oe_n", 8'h20, pin_oe_n)
      `CHK("ref_out", 1'h1, ref_out)
      wr(pfg_pkg::PFG_OFS_DIRECTION, 8'hff);
      settle(6);
      rd_chk("pins", pfg_pkg::PFG_OFS_PIN_LEVEL, 8'hdf);
      wr(pfg_pkg::PFG_OFS_VREF_CTRL, 8'h80);
      settle(1);
      `CHK("ref_out", 1'h0, ref_out)
      rd_chk("pins", pfg_pkg::PFG_OFS_PIN_LEVEL, 8'hff);
      $display("t_vref done");
   endtask

   task automatic t_slave();
      wr(pfg_pkg::PFG_OFS_DIRECTION, 8'h80);
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_sys);
         pin_in <= {1'(v), 7'h7f};
         settle(6);
         `CHK("ss_in", 1'(v), ss_in)
         rd_chk("pins", pfg_pkg::PFG_OFS_PIN_LEVEL, {1'(v), 7'h7f});
      end
      @(posedge clk_sys);
      pin_in <= 8'h7f;
      wr(pfg_pkg::PFG_OFS_DIRECTION, 8'h00);
      settle(6);
      `CHK("ss_in", 1'h1, ss_in)
      $display("t_slave done");
   endtask

   // ----------------------------------------------------------------
   // clock, reset, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end

   // cut a hang short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         n_fail++;
         print_verdict();
      end
   end

   // main sequence
   initial begin
      n_fail = 0;
      n_compared = 0;
      arst_n = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      pin_in = 8'hff;
      cmp1 = 1'h0;
      cmp2 = 1'h0;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      t_reset();
      t_digital();
      t_decode();
      t_comparators();
      t_vref();
      t_slave();
      print_verdict();
   end
endmodule

`default_nettype wire
